// [inc/sps_pkg.sv]
// Constants, types and helpers shared by the transceiver status/config block
package sps_pkg;

  // Lane layout of the status word
  localparam int NLANE  = 4;
  localparam int LFLAGS = 7;
  localparam int FLAG_W = NLANE * LFLAGS;

  // Register byte addresses
  localparam logic [31:0] STS_ADDR      = 32'h0262_0154;
  localparam logic [31:0] CFG_ADDR      = 32'h0262_0360;
  localparam logic [31:0] IRQ_STS_ADDR  = 32'h0262_0400;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h0262_0404;

  // Status word fields
  localparam int STS_LOCK_BIT  = 0;
  localparam int STS_LANE_LSB  = 1;
  localparam int STS_RSVD_LSB  = 29;
  localparam int STS_RSVD_W    = 3;

  // Flag order inside one lane, low to high
  localparam int F_RXFAIL = 0;
  localparam int F_ALIGN  = 1;
  localparam int F_LOS    = 2;
  localparam int F_OCB    = 3;
  localparam int F_UNDER  = 4;
  localparam int F_OVER   = 5;
  localparam int F_TXFAIL = 6;

  // Configuration word fields
  localparam int CFG_W         = 15;
  localparam int CFG_ON_BIT    = 0;
  localparam int CFG_MPY_LSB   = 1;
  localparam int CFG_MPY_W     = 8;
  localparam int CFG_VCO_BIT   = 9;
  localparam int CFG_SLEEP_BIT = 10;
  localparam int CFG_BW_LSB    = 11;
  localparam int CFG_BYP_LSB   = 13;
  localparam logic [1:0] BW_RSVD  = 2'h1;
  localparam logic [1:0] BYP_RSVD = 2'h1;
  localparam logic [CFG_W-1:0] CFG_RESET = 15'h0020; // Off, multiply 4x

  // Lock timing in reference clock cycles
  localparam logic [11:0] LOCK_DLY_REF  = 12'h800; // 2048
  localparam logic [11:0] LOCK_WAIT_REF = 12'h0c8; // 200

  // Interrupt status layout
  localparam int IRQ_W        = 10;
  localparam int IRQ_LOCK     = 0;
  localparam int IRQ_TMO      = 1;
  localparam int IRQ_LOS_LSB  = 2;
  localparam int IRQ_FAIL_LSB = 6;

  // PLL lock tracking states
  typedef enum logic [3:0] {
    ST_OFF    = 4'h1,
    ST_WAIT   = 4'h2,
    ST_DLY    = 4'h4,
    ST_LOCKED = 4'h8
  } sps_pll_e;

  // Samples per two PLL clocks for a lane rate code
  function automatic logic [3:0] sps_samples_x2(input logic [1:0] rate);
    case (rate)
      2'h0:    sps_samples_x2 = 4'h8;
      2'h1:    sps_samples_x2 = 4'h4;
      2'h2:    sps_samples_x2 = 4'h2;
      default: sps_samples_x2 = 4'h1;
    endcase
  endfunction : sps_samples_x2

endpackage : sps_pkg

// [inc/sps_flag_if.sv]
// Carrier for synchronised lane flags and their rising edges
`timescale 1ns/100ps
interface sps_flag_if;
  import sps_pkg::*;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] rise;
  modport src (output flags, output rise);
  modport dst (input flags, input rise);
endinterface : sps_flag_if

// [hdl/sps_flag_sync.sv]
// Two-stage synchroniser and edge finder for the raw lane flags
`timescale 1ns/100ps
module sps_flag_sync
  import sps_pkg::*;
#(
  parameter int W = FLAG_W
) (
  input  wire logic         i_clk,  // Core clock
  input  wire logic         i_nrst, // Async reset, low
  input  wire logic [W-1:0] i_raw,  // Flags from the analog macro
  sps_flag_if.src           o_f     // Synchronised flags
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sps_sync_s;

  sps_sync_s q;
  sps_sync_s d;

  // Refuse any width other than the lane layout width FLAG_W
  if (W != FLAG_W) begin : g_chk
    $error("flag width must match the lane layout");
  end

  // Shift chain; s1 feeds only s2
  always_comb begin
    d    = q;
    d.s1 = i_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Levels and rising edges for the register side
  assign o_f.flags = q.s2;
  assign o_f.rise  = q.s2 & ~q.s3;

endmodule : sps_flag_sync

// [hdl/sps_regs.sv]
// Transceiver PLL status and configuration register bank
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module sps_regs
  import sps_pkg::*;
(
  input  wire logic                 I_CORE_CLK,              // Core clock, 125 MHz
  input  wire logic                 I_NRST,                  // Async reset, low
  input  wire logic [31:0]          I_ADDR,                  // Register byte address
  input  wire logic [31:0]          I_WDATA,                 // Write data
  input  wire logic                 I_WR,                    // Write strobe
  input  wire logic                 I_RD,                    // Read strobe
  output logic      [31:0]          O_RDATA,                 // Read data, next cycle
  output logic                      O_IRQ,                   // Level interrupt
  input  wire logic                 I_REFERENCE_CLOCK_INPUT, // PLL reference clock pin
  input  wire logic                 I_PLL_LOCK_RAW,          // Raw PLL lock from macro
  input  wire logic [FLAG_W-1:0]    I_LANE_FLAGS,            // Raw lane flags
  input  wire logic [2*NLANE-1:0]   I_LANE_RATE,             // Lane rate codes
  output logic      [1:0]           O_PLL_BYPASS_SELECT,     // Clock bypass
  output logic      [1:0]           O_LOOP_BW,               // Loop bandwidth
  output logic                      O_PLL_SLEEP,             // PLL sleep
  output logic                      O_VCO_BAND_SELECT,       // VCO band, 1 low
  output logic      [CFG_MPY_W-1:0] O_PLL_MULTIPLIER_CODE,   // Multiply code
  output logic                      O_PLL_ON,                // PLL enable
  output logic      [4*NLANE-1:0]   O_SAMPLES_X2             // Samples per 2 PLL clocks
);

  // Register state of the block, apart from the lane flag synchroniser flops in u_sync
  typedef struct packed {
    logic                   lk1;
    logic                   lk2;
    logic                   rc1;
    logic                   rc2;
    logic                   rc3;
    sps_pll_e               st;
    logic [11:0]            cnt;
    logic                   tmo_done;
    logic                   lock;
    logic [CFG_W-1:0]       cfg;
    logic [IRQ_W-1:0]       ists;
    logic [IRQ_W-1:0]       imask;
    logic [31:0]            rdata;
    logic                   irq;
    logic [4*NLANE-1:0]     smp;
  } sps_top_s;

  sps_top_s           q;
  sps_top_s           d;
  logic [IRQ_W-1:0]   ev;
  logic               tick;
  logic               run;
  logic               wr_cfg;
  logic [CFG_W-1:0]   wcfg;

  sps_flag_if u_if ();

  // Lane flag synchroniser
  sps_flag_sync #(
    .W (FLAG_W)
  ) u_sync (
    .i_clk  (I_CORE_CLK),
    .i_nrst (I_NRST),
    .i_raw  (I_LANE_FLAGS),
    .o_f    (u_if)
  );

  // Status word image: reserved top, lanes, lock at bit 0
  function automatic logic [31:0] sts_word(input logic [FLAG_W-1:0] fl,
                                           input logic lk);
    sts_word                            = '0;
    sts_word[STS_LANE_LSB +: FLAG_W]    = fl;
    sts_word[STS_LOCK_BIT]              = lk;
  endfunction : sts_word

  // Next-state logic
  always_comb begin
    d      = q;
    ev     = '0;
    wcfg   = q.cfg;

    // Reference clock and lock pin synchronisers
    d.lk1  = I_PLL_LOCK_RAW;
    d.lk2  = q.lk1;
    d.rc1  = I_REFERENCE_CLOCK_INPUT;
    d.rc2  = q.rc1;
    d.rc3  = q.rc2;
    tick   = q.rc2 & ~q.rc3;

    // PLL runs while enabled and not asleep
    run    = q.cfg[CFG_ON_BIT] & ~q.cfg[CFG_SLEEP_BIT];

    // Lock tracking: wait for lock, then hold off 2048 ref edges
    case (q.st)
      ST_OFF: begin
        d.lock = 1'b0;
        if (run) begin
          d.st       = ST_WAIT;
          d.cnt      = '0;
          d.tmo_done = 1'b0;
        end
      end
      ST_WAIT: begin
        d.lock = 1'b0;
        if (!run) begin
          d.st = ST_OFF;
        end else if (q.lk2) begin
          d.st  = ST_DLY;
          d.cnt = '0;
        end else if (tick && !q.tmo_done) begin
          // Lock is due within 200 ref cycles
          if (q.cnt == LOCK_WAIT_REF - 12'h001) begin
            ev[IRQ_TMO] = 1'b1;
            d.tmo_done  = 1'b1;
          end else begin
            d.cnt = q.cnt + 12'h001;
          end
        end
      end
      ST_DLY: begin
        d.lock = 1'b0;
        if (!run) begin
          d.st = ST_OFF;
        end else if (!q.lk2) begin
          d.st  = ST_WAIT;
          d.cnt = '0;
        end else if (tick) begin
          if (q.cnt == LOCK_DLY_REF - 12'h001) begin
            d.st          = ST_LOCKED;
            d.lock        = 1'b1;
            ev[IRQ_LOCK]  = 1'b1;
          end else begin
            d.cnt = q.cnt + 12'h001;
          end
        end
      end
      ST_LOCKED: begin
        // Losing lock or power drops the flag at once
        if (!run || !q.lk2) begin
          d.lock = 1'b0;
          d.cnt  = '0;
          d.st   = run ? ST_WAIT : ST_OFF;
        end
      end
      default: begin
        d.st   = ST_OFF;
        d.lock = 1'b0;
      end
    endcase

    // Lane events: signal loss and test failure edges
    for (int i = 0; i < NLANE; i++) begin
      ev[IRQ_LOS_LSB + i]  = u_if.rise[i*LFLAGS + F_LOS];
      ev[IRQ_FAIL_LSB + i] = u_if.rise[i*LFLAGS + F_RXFAIL] |
                             u_if.rise[i*LFLAGS + F_TXFAIL];
    end

    // Configuration write; reserved field codes keep the old field
    wr_cfg = I_WR && (I_ADDR == CFG_ADDR);
    if (wr_cfg) begin
      wcfg = I_WDATA[CFG_W-1:0];
      if (I_WDATA[CFG_BW_LSB +: 2] == BW_RSVD) begin
        wcfg[CFG_BW_LSB +: 2] = q.cfg[CFG_BW_LSB +: 2];
      end
      if (I_WDATA[CFG_BYP_LSB +: 2] == BYP_RSVD) begin
        wcfg[CFG_BYP_LSB +: 2] = q.cfg[CFG_BYP_LSB +: 2];
      end
    end
    d.cfg = wcfg;

    // Mask register write
    if (I_WR && (I_ADDR == IRQ_MASK_ADDR)) begin
      d.imask = I_WDATA[IRQ_W-1:0];
    end

    // Sticky status: read clears, a new event wins
    if (I_RD && (I_ADDR == IRQ_STS_ADDR)) begin
      d.ists = ev;
    end else begin
      d.ists = q.ists | ev;
    end

    // Read decode; data stands one cycle only
    d.rdata = '0;
    if (I_RD) begin
      if (I_ADDR == STS_ADDR) begin
        d.rdata = sts_word(u_if.flags, q.lock);
      end else if (I_ADDR == CFG_ADDR) begin
        d.rdata[CFG_W-1:0] = q.cfg;
      end else if (I_ADDR == IRQ_STS_ADDR) begin
        d.rdata[IRQ_W-1:0] = q.ists;
      end else if (I_ADDR == IRQ_MASK_ADDR) begin
        d.rdata[IRQ_W-1:0] = q.imask;
      end else begin
        d.rdata = '0;
      end
    end

    // Interrupt level from unmasked sticky bits
    d.irq = |(d.ists & d.imask);

    // Per-lane sample rate; PLL clock is 2^rate/4 of line rate
    for (int i = 0; i < NLANE; i++) begin
      d.smp[4*i +: 4] = sps_samples_x2(I_LANE_RATE[2*i +: 2]);
    end
  end

  // State register
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      q       <= '0;
      q.st    <= ST_OFF;
      q.cfg   <= CFG_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign O_RDATA               = q.rdata;
  assign O_IRQ                 = q.irq;
  assign O_PLL_BYPASS_SELECT   = q.cfg[CFG_BYP_LSB +: 2];
  assign O_LOOP_BW             = q.cfg[CFG_BW_LSB +: 2];
  assign O_PLL_SLEEP           = q.cfg[CFG_SLEEP_BIT];
  assign O_VCO_BAND_SELECT     = q.cfg[CFG_VCO_BIT];
  assign O_PLL_MULTIPLIER_CODE = q.cfg[CFG_MPY_LSB +: CFG_MPY_W];
  assign O_PLL_ON              = q.cfg[CFG_ON_BIT];
  assign O_SAMPLES_X2          = q.smp;

  // Checks on the block's own behaviour
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_NRST);

  // Lock flag rises only at the end of the full hold-off count
  a_lock_delay:
    assert property ($rose(q.lock) |->
                     $past(q.st) == ST_DLY && $past(q.cnt) == LOCK_DLY_REF - 12'h001)
    else $error("lock flag rose before hold-off ended");

  // Disabling the PLL clears the lock flag
  a_lock_drop:
    assert property (!q.cfg[CFG_ON_BIT] |=> !q.lock)
    else $error("lock flag stayed high with PLL off");

  // Lane flags appear in the status word in place
  a_status_map:
    assert property ((I_RD && I_ADDR == STS_ADDR) |=>
                     O_RDATA[STS_LANE_LSB +: FLAG_W] == $past(u_if.flags))
    else $error("status word lane flags misplaced");

  // Reserved status bits read zero, lock bit mirrors the flag
  a_status_rsvd:
    assert property ((I_RD && I_ADDR == STS_ADDR) |=>
                     O_RDATA[STS_RSVD_LSB +: STS_RSVD_W] == '0 &&
                     O_RDATA[STS_LOCK_BIT] == $past(q.lock))
    else $error("status reserved or lock bit wrong");

  // Bypass takes a valid written code
  a_bypass_wr:
    assert property ((wr_cfg && I_WDATA[CFG_BYP_LSB +: 2] != BYP_RSVD) |=>
                     O_PLL_BYPASS_SELECT == $past(I_WDATA[CFG_BYP_LSB +: 2]))
    else $error("bypass field not written");

  // Reserved bandwidth code leaves the field alone
  a_bw_rsvd:
    assert property ((wr_cfg && I_WDATA[CFG_BW_LSB +: 2] == BW_RSVD) |=>
                     $stable(O_LOOP_BW))
    else $error("reserved bandwidth code accepted");

  // Sleep bit follows write and holds lock down
  a_sleep_wr:
    assert property (wr_cfg |=> O_PLL_SLEEP == $past(I_WDATA[CFG_SLEEP_BIT])
                     ##1 (!O_PLL_SLEEP || !q.lock))
    else $error("sleep bit or lock wrong after write");

  // VCO band follows write
  a_vco_wr:
    assert property (wr_cfg |=> O_VCO_BAND_SELECT == $past(I_WDATA[CFG_VCO_BIT]))
    else $error("VCO band not written");

  // Multiply code follows write
  a_mpy_wr:
    assert property (wr_cfg |=>
                     O_PLL_MULTIPLIER_CODE == $past(I_WDATA[CFG_MPY_LSB +: CFG_MPY_W]))
    else $error("multiply code not written");

  // Enable bit follows write; config reads back with upper bits zero
  a_pll_on_wr:
    assert property (wr_cfg ##1 (I_RD && I_ADDR == CFG_ADDR) |=>
                     O_RDATA[CFG_ON_BIT] == $past(I_WDATA[CFG_ON_BIT], 2) &&
                     O_RDATA[31:CFG_W] == '0)
    else $error("config readback wrong");

  // Full rate gives four samples per PLL clock
  a_full_rate:
    assert property (I_LANE_RATE[1:0] == 2'h0 |=> O_SAMPLES_X2[3:0] == 4'h8)
    else $error("full rate sample count wrong");

  // A write to the status word leaves the config and mask registers alone
  a_status_ro:
    assert property ((I_WR && I_ADDR == STS_ADDR) |=> $stable(q.cfg) && $stable(q.imask))
    else $error("status write changed a register");

  // Lost lock or stopped PLL drops the flag and leaves the locked state
  a_lock_lost:
    assert property ((q.st == ST_LOCKED && (!run || !q.lk2)) |=>
                     !q.lock && q.st != ST_LOCKED)
    else $error("lock flag held after lock was lost");

  // A signal loss edge on lane zero is kept in the sticky status
  a_los_sticky:
    assert property (u_if.rise[F_LOS] |=> q.ists[IRQ_LOS_LSB])
    else $error("signal loss event not recorded");

  // Config read returns the whole word with reserved bits zero
  a_cfg_read:
    assert property ((I_RD && I_ADDR == CFG_ADDR) |=>
                     O_RDATA[31:CFG_W] == '0 && O_RDATA[CFG_W-1:0] == $past(q.cfg))
    else $error("config read data wrong");

  // Eighth rate gives one sample per two PLL clocks
  a_eighth_rate:
    assert property (I_LANE_RATE[2*NLANE-1 -: 2] == 2'h3 |=>
                     O_SAMPLES_X2[4*NLANE-1 -: 4] == 4'h1)
    else $error("eighth rate sample count wrong");

  // Main scenarios
  c_sleep:   cover property (wr_cfg && I_WDATA[CFG_SLEEP_BIT]);
  c_locked:  cover property ($rose(q.lock));
  c_timeout: cover property (ev[IRQ_TMO]);
  c_irq:     cover property ($rose(O_IRQ));
  c_los:     cover property (|ev[IRQ_LOS_LSB +: NLANE]);

endmodule : sps_regs

// [test/sps_macro_model.sv]
// Behavioural transceiver macro: reference clock, raw PLL lock and raw lane flags
`timescale 1ns/100ps
module sps_macro_model #(
  parameter int LOCK_AT = 100 // Ref cycles from start to lock
) (
  input  wire logic        i_run,   // PLL enabled and awake
  input  wire logic        i_hold,  // Keep the PLL from locking
  input  wire logic [27:0] i_flags, // Wanted lane flag levels
  output logic             o_ref,   // Reference clock, half core rate
  output logic             o_lock,  // Raw lock level
  output wire logic [27:0] o_flags  // Raw lane flags
);
  int n = 0;

  // Reference clock runs free at half the core rate
  initial begin
    o_ref = 1'b0;
    o_lock = 1'b0;
  end
  always #8 o_ref = ~o_ref;

  // Lock well inside the allowed span, lost as soon as the PLL stops
  always @(posedge o_ref or negedge i_run) begin
    if (!i_run) begin
      n <= 0;
      o_lock <= 1'b0;
    end else begin
      n <= n + 1;
      o_lock <= !i_hold && (n >= LOCK_AT);
    end
  end

  // Flags move off any core clock edge
  assign #3 o_flags = i_flags;
endmodule : sps_macro_model

// [test/tb_top.sv]
// Self-checking bench for the transceiver status and configuration bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import sps_pkg::*;
  typedef struct {logic [31:0] wd; logic [31:0] rb; logic [7:0] rt; logic [15:0] sx;} sps_row_s;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        hold = 1'b0;
  logic [31:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [27:0] flags_want = '0;
  logic [7:0]  rate = '0;
  logic [31:0] rdata, got;
  logic [27:0] flags_raw;
  logic [15:0] smp;
  logic [7:0]  pll_multiplier_code;
  logic [1:0]  byp, bw;
  logic        irq, sleep, vco, on, ref_clk, lock_raw;
  int          fails = 0;
  int          compares = 0;
  int          ref_n = 0;
  int          t0;
  sps_row_s    rows [5] = '{'{32'h0000_7fff, 32'h0000_7fff, 8'he4, 16'h1248},
                            '{32'hffff_0000, 32'h0000_0000, 8'h1b, 16'h8421},
                            '{32'h0000_5028, 32'h0000_5028, 8'h00, 16'h8888},
                            '{32'h0000_2800, 32'h0000_5000, 8'hff, 16'h1111},
                            '{32'h0000_00c8, 32'h0000_00c8, 8'h55, 16'h4444}};

  // Core clock 125 MHz, and a count of reference edges for lock timing
  always #4 clk = ~clk;
  always @(posedge ref_clk) ref_n++;

  sps_regs i_dut (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_IRQ(irq), .I_REFERENCE_CLOCK_INPUT(ref_clk),
    .I_PLL_LOCK_RAW(lock_raw), .I_LANE_FLAGS(flags_raw), .I_LANE_RATE(rate),
    .O_PLL_BYPASS_SELECT(byp), .O_LOOP_BW(bw), .O_PLL_SLEEP(sleep),
    .O_VCO_BAND_SELECT(vco), .O_PLL_MULTIPLIER_CODE(pll_multiplier_code), .O_PLL_ON(on), .O_SAMPLES_X2(smp));

  sps_macro_model i_macro (
    .i_run(on & ~sleep), .i_hold(hold), .i_flags(flags_want),
    .o_ref(ref_clk), .o_lock(lock_raw), .o_flags(flags_raw));

  // One-cycle write strobe; outputs settled one edge later
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // One-cycle read strobe; data taken in the cycle after it
  task automatic rd_reg(input logic [31:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg

  // Bounded wait for the interrupt line
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk);
    #1;
  endtask : wait_irq

  task automatic close_out;
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // Watchdog cuts a hang short
  initial begin
    #400000;
    fails++;
    close_out;
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    `CHK("cfg_reset", 15'h0020, {byp, bw, sleep, vco, pll_multiplier_code, on})
    `CHK("irq_reset", 1'b0, irq)
    `CHK("rdata_reset", 32'h0, rdata)
    @(posedge clk) nrst <= 1'b1;
    // Configuration fields, reserved codes and lane rate decode
    foreach (rows[i]) begin
      rate <= rows[i].rt;
      wr_reg(CFG_ADDR, rows[i].wd);
      `CHK("cfg_pins", rows[i].rb[14:0], {byp, bw, sleep, vco, pll_multiplier_code, on})
      `CHK("samples", rows[i].sx, smp)
      rd_reg(CFG_ADDR);
      `CHK("cfg_read", rows[i].rb, got)
    end
    // Each flag kind in every lane lands at its status bit
    for (int f = 0; f < LFLAGS; f++) begin
      flags_want <= 28'h0204081 << f;
      repeat (6) @(posedge clk);
      rd_reg(STS_ADDR);
      `CHK("status", {3'h0, 28'h0204081 << f, 1'b0}, got)
    end
    `CHK("irq_masked", 1'b0, irq)
    rd_reg(IRQ_STS_ADDR);
    `CHK("irq_events", 32'h3fc, got)
    rd_reg(IRQ_STS_ADDR);
    `CHK("irq_cleared", 32'h0, got)
    flags_want <= '0;
    // Status is read-only; unmapped space reads zero
    wr_reg(STS_ADDR, 32'hffff_ffff);
    repeat (6) @(posedge clk);
    rd_reg(STS_ADDR);
    `CHK("status_ro", 32'h0, got)
    rd_reg(32'h0262_0158);
    `CHK("unmapped", 32'h0, got)
    // Unmasked signal loss on lane 1 raises the line; reading clears it
    wr_reg(IRQ_MASK_ADDR, 32'h8);
    flags_want <= 28'h0000200;
    wait_irq(10);
    `CHK("irq_los", 1'b1, irq)
    rd_reg(IRQ_STS_ADDR);
    `CHK("irq_los_sts", 32'h8, got)
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq_drop", 1'b0, irq)
    flags_want <= '0;
    // Lock flag appears inside its window after the raw lock
    wr_reg(IRQ_MASK_ADDR, 32'h1);
    wr_reg(CFG_ADDR, 32'h21);
    wait (lock_raw === 1'b1);
    t0 = ref_n;
    wait_irq(7000);
    `CHK("lock_irq", 1'b1, irq)
    `CHK("lock_win", 1'b1, (ref_n - t0 >= 2048) && (ref_n - t0 <= 3071))
    rd_reg(STS_ADDR);
    `CHK("lock_flag", 32'h1, got)
    wr_reg(CFG_ADDR, 32'h421);
    repeat (6) @(posedge clk);
    rd_reg(STS_ADDR);
    `CHK("sleep_lock", 32'h0, got)
    // A PLL that never locks reports a timeout after 200 ref cycles
    hold <= 1'b1;
    wr_reg(CFG_ADDR, 32'h20);
    rd_reg(IRQ_STS_ADDR);
    wr_reg(IRQ_MASK_ADDR, 32'h2);
    t0 = ref_n;
    // Write then read back with no idle cycle between the strobes
    @(posedge clk);
    wr <= 1'b1;
    addr <= CFG_ADDR;
    wdata <= 32'h0000_0021;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    `CHK("cfg_b2b", 32'h21, got)
    wait_irq(600);
    `CHK("tmo_win", 1'b1, (ref_n - t0 >= 199) && (ref_n - t0 <= 208))
    rd_reg(IRQ_STS_ADDR);
    `CHK("tmo_sts", 32'h2, got)
    // Reset in mid-run restores the defaults
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("cfg_rst2", 15'h0020, {byp, bw, sleep, vco, pll_multiplier_code, on})
    `CHK("smp_rst2", 16'h0, smp)
    `CHK("irq_rst2", 1'b0, irq)
    @(posedge clk) nrst <= 1'b1;
    rd_reg(CFG_ADDR);
    `CHK("cfg_after_rst", 32'h20, got)
    close_out;
  end
endmodule : tb_top
